// File: design/ale_pkg.sv
package ale_pkg;

    // ----------------------------------------------------------------
    // widths and field positions of the 14-bit instruction word
    // ----------------------------------------------------------------
    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;
    localparam int INSTR_W = 14;
    localparam int BIT_W = 3;
    localparam int LIT_LSB = 0;
    localparam int ADDR_LSB = 0;
    localparam int DEST_POS = 7;
    localparam int BSEL_LSB = 7;

    // ----------------------------------------------------------------
    // opcode patterns, compared on the top bits of the word
    // ----------------------------------------------------------------
    localparam logic [5:0] OPC_ADD_ACC_REG = 6'h07;
    localparam logic [5:0] OPC_AND_ACC_REG = 6'h05;
    localparam logic [5:0] OPC_AND_LIT = 6'h39;
    localparam logic [4:0] OPC_ADD_LIT = 5'h1f;
    localparam logic [3:0] OPC_BIT_CLEAR = 4'h4;
    localparam logic [3:0] OPC_BIT_SET = 4'h5;
    localparam logic [3:0] OPC_SKIP_ZERO = 4'h6;
    localparam logic [3:0] OPC_SKIP_ONE = 4'h7;

    // ----------------------------------------------------------------
    // reset values and byte constants
    // ----------------------------------------------------------------
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [7:0] BIT_ONE = 8'h01;
    localparam logic [7:0] ZERO_BYTE = 8'h00;

    typedef enum logic [3:0] {
        ALE_OP_NONE = 4'h0,
        ALE_OP_ADD_LIT = 4'h1,
        ALE_OP_AND_LIT = 4'h2,
        ALE_OP_ADD_REG = 4'h3,
        ALE_OP_AND_REG = 4'h4,
        ALE_OP_BIT_CLR = 4'h5,
        ALE_OP_BIT_SET = 4'h6,
        ALE_OP_SKIP_ONE = 4'h7,
        ALE_OP_SKIP_ZERO = 4'h8
    } ale_op_t;

    typedef enum logic {
        ALE_ST_EXEC = 1'b0,
        ALE_ST_DISCARD = 1'b1
    } ale_state_t;

    typedef struct packed {
        logic carry;
        logic nibble_out_bit;
        logic zero;
    } ale_flags_t;

    typedef struct packed {
        logic [7:0] res;
        ale_flags_t flg;
        logic upd_carry;
        logic upd_zero;
        logic skip;
    } ale_alu_out_t;

endpackage

// File: design/ale_alu.sv
`timescale 1ns/1ps
`default_nettype none
module ale_alu (
    input wire ale_pkg::ale_op_t op,
    input wire logic [7:0] acc,
    input wire logic [7:0] operand,
    input wire logic [2:0] bsel,
    output ale_pkg::ale_alu_out_t o
);
    logic [8:0] sum9;
    logic [4:0] nib5;
    logic [7:0] mask;

    always_comb begin
        sum9 = {1'b0, acc} + {1'b0, operand};
        nib5 = {1'b0, acc[3:0]} + {1'b0, operand[3:0]};
        mask = 8'(ale_pkg::BIT_ONE << bsel);
        o = '0;
        unique case (op)
            ale_pkg::ALE_OP_ADD_LIT, ale_pkg::ALE_OP_ADD_REG: begin
                o.res = sum9[7:0];
                o.flg.carry = sum9[8];
                o.flg.nibble_out_bit = nib5[4];
                o.upd_carry = 1'b1;
                o.upd_zero = 1'b1;
            end
            ale_pkg::ALE_OP_AND_LIT, ale_pkg::ALE_OP_AND_REG: begin
                o.res = acc & operand;
                o.upd_zero = 1'b1;
            end
            ale_pkg::ALE_OP_BIT_CLR: begin
                o.res = operand & ~mask;
            end
            ale_pkg::ALE_OP_BIT_SET: begin
                o.res = operand | mask;
            end
            ale_pkg::ALE_OP_SKIP_ONE: begin
                o.skip = |(operand & mask);
            end
            ale_pkg::ALE_OP_SKIP_ZERO: begin
                o.skip = ~|(operand & mask);
            end
            default: begin
                o.res = ale_pkg::ZERO_BYTE;
            end
        endcase
        o.flg.zero = (o.res == ale_pkg::ZERO_BYTE);
    end
endmodule
`default_nettype wire

// File: design/ale_exec.sv
// Notes on behaviour
// - add-literal adds literal to accumulator; carry, nibble, zero set.
// - and-literal ands literal into accumulator; only zero flag updated.
// - add-register adds accumulator and register 0..127; all flags set.
// - destination bit 0 writes accumulator, 1 writes the file register.
// - and-register ands accumulator with register; only zero updated.
// - bit clear forces chosen bit 0..7 to zero; flags untouched.
// - bit set forces chosen bit to one; flags untouched.
// - skip-when-one discards next instruction as idle slot if bit is one.
// - skip-when-zero discards next instruction as idle slot on a 0 bit.
// - a true skip takes two instruction slots; the second is an idle slot.
`timescale 1ns/1ps
`default_nettype none
module ale_exec #(
    parameter int FILE_DEPTH = 128
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic instr_valid,
    input wire logic [13:0] instr,
    input wire logic ext_we,
    input wire logic [6:0] ext_addr,
    input wire logic [7:0] ext_wdata,
    output logic [7:0] ext_rdata_r,
    output logic [7:0] acc_r,
    output ale_pkg::ale_flags_t flags_r,
    output logic done_r,
    output logic idle_slot_r,
    output logic skip_pending_r
);
    if (FILE_DEPTH != 2 ** ale_pkg::ADDR_W) begin : g_chk
        $error("FILE_DEPTH must match the 7-bit file address");
    end

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    ale_pkg::ale_state_t state_r, state_nxt;
    ale_pkg::ale_op_t op;
    ale_pkg::ale_alu_out_t alu_o;
    logic [7:0] file_mem [FILE_DEPTH];
    logic [6:0] faddr;
    logic [2:0] bsel;
    logic [7:0] lit;
    logic [7:0] fval;
    logic [7:0] operand;
    logic dest_file;
    logic taken;

    assign faddr = instr[ale_pkg::ADDR_LSB +: ale_pkg::ADDR_W];
    assign bsel = instr[ale_pkg::BSEL_LSB +: ale_pkg::BIT_W];
    assign lit = instr[ale_pkg::LIT_LSB +: ale_pkg::DATA_W];
    assign dest_file = instr[ale_pkg::DEST_POS];
    assign fval = file_mem[faddr];
    assign taken = instr_valid && (state_r == ale_pkg::ALE_ST_EXEC);

    always_comb begin
        op = ale_pkg::ALE_OP_NONE;
        if (instr[13:9] == ale_pkg::OPC_ADD_LIT) begin
            op = ale_pkg::ALE_OP_ADD_LIT;
        end else if (instr[13:8] == ale_pkg::OPC_AND_LIT) begin
            op = ale_pkg::ALE_OP_AND_LIT;
        end else if (instr[13:8] == ale_pkg::OPC_ADD_ACC_REG) begin
            op = ale_pkg::ALE_OP_ADD_REG;
        end else if (instr[13:8] == ale_pkg::OPC_AND_ACC_REG) begin
            op = ale_pkg::ALE_OP_AND_REG;
        end else if (instr[13:10] == ale_pkg::OPC_BIT_CLEAR) begin
            op = ale_pkg::ALE_OP_BIT_CLR;
        end else if (instr[13:10] == ale_pkg::OPC_BIT_SET) begin
            op = ale_pkg::ALE_OP_BIT_SET;
        end else if (instr[13:10] == ale_pkg::OPC_SKIP_ONE) begin
            op = ale_pkg::ALE_OP_SKIP_ONE;
        end else if (instr[13:10] == ale_pkg::OPC_SKIP_ZERO) begin
            op = ale_pkg::ALE_OP_SKIP_ZERO;
        end
    end

    always_comb begin
        if (op == ale_pkg::ALE_OP_ADD_LIT
            || op == ale_pkg::ALE_OP_AND_LIT) begin
            operand = lit;
        end else begin
            operand = fval;
        end
    end

    ale_alu u_alu (
        .op(op),
        .acc(acc_r),
        .operand(operand),
        .bsel(bsel),
        .o(alu_o)
    );

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    logic [7:0] acc_nxt;
    ale_pkg::ale_flags_t flags_nxt;
    logic done_nxt;
    logic idle_nxt;
    logic file_we;
    logic [7:0] file_wdata;
    logic [6:0] file_waddr;
    logic skip_nxt;
    logic [7:0] rdata_nxt;

    always_comb begin
        acc_nxt = acc_r;
        flags_nxt = flags_r;
        state_nxt = state_r;
        done_nxt = 1'b0;
        idle_nxt = 1'b0;
        file_we = ext_we;
        file_waddr = ext_addr;
        file_wdata = ext_wdata;
        unique case (state_r)
            ale_pkg::ALE_ST_EXEC: begin
                if (instr_valid) begin
                    done_nxt = 1'b1;
                    if (alu_o.upd_carry) begin
                        flags_nxt.carry = alu_o.flg.carry;
                        flags_nxt.nibble_out_bit = alu_o.flg.nibble_out_bit;
                    end
                    if (alu_o.upd_zero) begin
                        flags_nxt.zero = alu_o.flg.zero;
                    end
                    unique case (op)
                        ale_pkg::ALE_OP_ADD_LIT, ale_pkg::ALE_OP_AND_LIT: begin
                            acc_nxt = alu_o.res;
                        end
                        ale_pkg::ALE_OP_ADD_REG, ale_pkg::ALE_OP_AND_REG: begin
                            if (dest_file) begin
                                file_we = 1'b1;
                                file_waddr = faddr;
                                file_wdata = alu_o.res;
                            end else begin
                                acc_nxt = alu_o.res;
                            end
                        end
                        ale_pkg::ALE_OP_BIT_CLR, ale_pkg::ALE_OP_BIT_SET: begin
                            file_we = 1'b1;
                            file_waddr = faddr;
                            file_wdata = alu_o.res;
                        end
                        default: begin
                            acc_nxt = acc_r;
                        end
                    endcase
                    if (alu_o.skip) begin
                        state_nxt = ale_pkg::ALE_ST_DISCARD;
                    end
                end
            end
            ale_pkg::ALE_ST_DISCARD: begin
                if (instr_valid) begin
                    idle_nxt = 1'b1;
                    state_nxt = ale_pkg::ALE_ST_EXEC;
                end
            end
        endcase
        skip_nxt = (state_nxt == ale_pkg::ALE_ST_DISCARD);
        rdata_nxt = file_mem[ext_addr];
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_r <= ale_pkg::ALE_ST_EXEC;
            acc_r <= ale_pkg::ACC_RESET;
            flags_r <= '0;
            done_r <= 1'b0;
            idle_slot_r <= 1'b0;
            skip_pending_r <= 1'b0;
            ext_rdata_r <= ale_pkg::ZERO_BYTE;
        end else begin
            state_r <= state_nxt;
            acc_r <= acc_nxt;
            flags_r <= flags_nxt;
            done_r <= done_nxt;
            idle_slot_r <= idle_nxt;
            skip_pending_r <= skip_nxt;
            ext_rdata_r <= rdata_nxt;
        end
    end

    // file registers carry no reset; preload them over the side port
    always_ff @(posedge clk) begin
        if (file_we) begin
            file_mem[file_waddr] <= file_wdata;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    logic [8:0] chk_sum;
    logic [4:0] chk_nib;
    assign chk_sum = {1'b0, acc_r} + {1'b0, operand};
    assign chk_nib = {1'b0, acc_r[3:0]} + {1'b0, operand[3:0]};

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_skip_true;
        taken && alu_o.skip;
    endsequence
    sequence s_discard_next;
        (state_r == ale_pkg::ALE_ST_DISCARD) ##0 instr_valid;
    endsequence

    a_add_lit_acc: assert property (
        taken && op == ale_pkg::ALE_OP_ADD_LIT
        |=> acc_r == 8'($past(acc_r) + $past(lit)))
        else $error("add literal result wrong");
    a_and_lit_flags: assert property (
        taken && op == ale_pkg::ALE_OP_AND_LIT
        |=> flags_r.zero == ($past(acc_r & lit) == ale_pkg::ZERO_BYTE)
        && flags_r.carry == $past(flags_r.carry))
        else $error("and literal flags wrong");
    a_add_reg_flags: assert property (
        taken && op == ale_pkg::ALE_OP_ADD_REG
        |=> flags_r.carry == $past(chk_sum[8])
        && flags_r.nibble_out_bit == $past(chk_nib[4]))
        else $error("add register carries wrong");
    a_dest_file_hold: assert property (
        taken && dest_file
        && (op == ale_pkg::ALE_OP_ADD_REG || op == ale_pkg::ALE_OP_AND_REG)
        |=> $stable(acc_r))
        else $error("file destination touched accumulator");
    a_and_reg_zero: assert property (
        taken && !dest_file && op == ale_pkg::ALE_OP_AND_REG
        |=> acc_r == $past(acc_r & fval)
        && flags_r.zero == ($past(acc_r & fval) == ale_pkg::ZERO_BYTE)
        && flags_r.nibble_out_bit == $past(flags_r.nibble_out_bit))
        else $error("and register result wrong");
    a_bit_clr_bit: assert property (
        taken && op == ale_pkg::ALE_OP_BIT_CLR
        |=> !file_mem[$past(faddr)][$past(bsel)]
        && $stable(flags_r))
        else $error("bit clear failed");
    a_bit_set_bit: assert property (
        taken && op == ale_pkg::ALE_OP_BIT_SET
        |=> file_mem[$past(faddr)][$past(bsel)]
        && $stable(flags_r))
        else $error("bit set failed");
    a_skip_enters: assert property (
        s_skip_true
        |=> skip_pending_r && $stable(flags_r))
        else $error("true skip did not arm discard");
    a_skip_false_runs: assert property (
        taken && !alu_o.skip
        |=> !skip_pending_r)
        else $error("false skip armed discard");
    a_discard_idle: assert property (
        s_discard_next
        |=> idle_slot_r && !done_r && $stable(acc_r) && $stable(flags_r)
        && !skip_pending_r)
        else $error("discarded slot had effect");
    a_zero_flag: assert property (
        taken && op == ale_pkg::ALE_OP_ADD_LIT
        |=> flags_r.zero == (acc_r == ale_pkg::ZERO_BYTE))
        else $error("zero flag mismatch");
endmodule
`default_nettype wire

// File: verif/test_arith_logic_bitop_exec.sv
`timescale 1ns/1ps
`default_nettype none
module test_arith_logic_bitop_exec;

    // ----------------------------------------------------------------
    // signals, model state, queues
    // ----------------------------------------------------------------
    `define CHK(g, e) begin \
        checks++; \
        if ((g) !== (e)) begin \
            fail_count++; \
            $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); \
        end \
    end
    logic clk;
    logic reset;
    logic instr_valid;
    logic [13:0] instr;
    logic ext_we;
    logic [6:0] ext_addr;
    logic [7:0] ext_wdata;
    logic [7:0] ext_rdata_r;
    logic [7:0] acc_r;
    ale_pkg::ale_flags_t flags_r;
    logic done_r;
    logic idle_slot_r;
    logic skip_pending_r;
    int fail_count;
    int checks;
    logic [7:0] m_mem [128];
    logic [7:0] m_acc;
    ale_pkg::ale_flags_t m_flg;
    logic m_skip;
    logic [13:0] notes [$];
    logic [7:0] rd_exp [$];
    logic rd_now;
    logic rd;
    logic [13:0] m_exp;

    ale_exec #(.FILE_DEPTH(128)) dut (
        .clk(clk),
        .reset(reset),
        .instr_valid(instr_valid),
        .instr(instr),
        .ext_we(ext_we),
        .ext_addr(ext_addr),
        .ext_wdata(ext_wdata),
        .ext_rdata_r(ext_rdata_r),
        .acc_r(acc_r),
        .flags_r(flags_r),
        .done_r(done_r),
        .idle_slot_r(idle_slot_r),
        .skip_pending_r(skip_pending_r)
    );

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // ----------------------------------------------------------------
    // reference model
    // ----------------------------------------------------------------
    function automatic logic [7:0] add8(input logic [7:0] a,
                                        input logic [7:0] c);
        logic [8:0] s;
        logic [4:0] h;
        s = {1'b0, a} + {1'b0, c};
        h = {1'b0, a[3:0]} + {1'b0, c[3:0]};
        m_flg = {s[8], h[4], s[7:0] == 8'h00};
        return s[7:0];
    endfunction

    function automatic logic [7:0] and8(input logic [7:0] a,
                                        input logic [7:0] c);
        m_flg.zero = (a & c) == 8'h00;
        return a & c;
    endfunction

    task automatic model(input logic [13:0] w);
        logic [6:0] f;
        logic [7:0] r;
        f = w[6:0];
        if (m_skip) begin
            m_skip = 1'b0;
            notes.push_back({2'b10, m_acc, m_flg, 1'b0});
            return;
        end
        if (w[13:9] == 5'h1f) m_acc = add8(m_acc, w[7:0]);
        else if (w[13:8] == 6'h39) m_acc = and8(m_acc, w[7:0]);
        else if (w[13:8] == 6'h07 || w[13:8] == 6'h05) begin
            if (w[13:8] == 6'h07) r = add8(m_acc, m_mem[f]);
            else r = and8(m_acc, m_mem[f]);
            if (w[7]) m_mem[f] = r;
            else m_acc = r;
        end
        else if (w[13:10] == 4'h4) m_mem[f][w[9:7]] = 1'b0;
        else if (w[13:10] == 4'h5) m_mem[f][w[9:7]] = 1'b1;
        else if (w[13:10] == 4'h6) m_skip = ~m_mem[f][w[9:7]];
        else if (w[13:10] == 4'h7) m_skip = m_mem[f][w[9:7]];
        notes.push_back({2'b01, m_acc, m_flg, m_skip});
    endtask

    function automatic logic [13:0] rand_word(input int k);
        logic [13:0] r;
        r = 14'($urandom);
        case (k)
            0: return {5'h1f, r[8:0]};
            1: return {6'h39, r[7:0]};
            2: return {6'h07, r[7:0]};
            3: return {6'h05, r[7:0]};
            4: return {4'h4, r[9:0]};
            5: return {4'h5, r[9:0]};
            6: return {4'h6, r[9:0]};
            7: return {4'h7, r[9:0]};
            default: return {6'h08, r[7:0]};
        endcase
    endfunction

    // ----------------------------------------------------------------
    // drivers
    // ----------------------------------------------------------------
    task automatic issue(input logic [13:0] w);
        @(posedge clk);
        instr_valid <= 1'b1;
        instr <= w;
        model(w);
    endtask

    task automatic gap();
        @(posedge clk);
        instr_valid <= 1'b0;
        instr <= 14'($urandom);
    endtask

    task automatic tally_and_finish();
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // monitor
    // ----------------------------------------------------------------
    initial forever begin
        @(posedge clk);
        rd = rd_now;
        #1;
        if (rd === 1'b1) `CHK(ext_rdata_r, rd_exp.pop_front())
        if (done_r === 1'b1 || idle_slot_r === 1'b1) begin
            m_exp = notes.size() > 0 ? notes.pop_front() : 14'h3fff;
            `CHK({idle_slot_r, done_r}, m_exp[13:12])
            `CHK(acc_r, m_exp[11:4])
            `CHK(flags_r, m_exp[3:1])
            `CHK(skip_pending_r, m_exp[0])
        end
    end

    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        tally_and_finish();
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        reset = 1'b1;
        instr_valid = 1'b0;
        instr = 14'h0000;
        ext_we = 1'b0;
        ext_addr = 7'h00;
        ext_wdata = 8'h00;
        rd_now = 1'b0;
        fail_count = 0;
        checks = 0;
        m_acc = 8'h00;
        m_flg = 3'h0;
        m_skip = 1'b0;
        void'($urandom(40));
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        for (int a = 0; a < 128; a++) begin
            @(posedge clk);
            ext_we <= 1'b1;
            ext_addr <= 7'(a);
            ext_wdata <= 8'($urandom);
            #1 m_mem[a] = ext_wdata;
        end
        @(posedge clk);
        ext_we <= 1'b0;
        issue(14'h3eff);
        issue(14'h3e01);
        issue(14'h3900);
        issue({4'h5, 3'd3, 7'h05});
        issue({4'h7, 3'd3, 7'h05});
        gap();
        issue(14'h3e05);
        issue({4'h4, 3'd7, 7'h7f});
        issue({4'h6, 3'd7, 7'h7f});
        issue({4'h7, 3'd3, 7'h05});
        issue(14'h3e01);
        issue({6'h07, 1'b1, 7'h7f});
        issue({6'h05, 1'b0, 7'h00});
        for (int i = 0; i < 700; i++) begin
            if (i == 500) begin
                gap();
                gap();
                @(posedge clk);
                reset <= 1'b1;
                repeat (2) @(posedge clk);
                #1 `CHK({acc_r, flags_r, done_r, idle_slot_r, skip_pending_r},
                    14'h0000)
                @(posedge clk);
                reset <= 1'b0;
                m_acc = 8'h00;
                m_flg = 3'h0;
                m_skip = 1'b0;
            end
            if ($urandom_range(0, 3) == 0) gap();
            issue(rand_word($urandom_range(0, 8)));
        end
        gap();
        gap();
        for (int a = 0; a < 128; a++) begin
            @(posedge clk);
            ext_addr <= 7'(a);
            rd_now <= 1'b1;
            rd_exp.push_back(m_mem[a]);
        end
        @(posedge clk);
        rd_now <= 1'b0;
        repeat (3) @(posedge clk);
        `CHK(notes.size() + rd_exp.size(), 0)
        tally_and_finish();
    end

endmodule
`default_nettype wire
